//--- common/fdrc_pkg.sv
package fdrc_pkg;
	localparam logic [4:0] OP_READ_DATA = 5'h06;
	localparam logic [4:0] OP_READ_DELETED = 5'h0c;
	localparam logic [4:0] OP_READ_TRACK = 5'h02;
	localparam logic [4:0] OP_READ_ID = 5'h0a;
	localparam int MT_BIT = 7;
	localparam int DD_BIT = 6;
	localparam int SKIP_BIT = 5;
	localparam int SIDE_BIT = 2;
	// command byte positions
	localparam logic [3:0] IX_OPC = 4'h0;
	localparam logic [3:0] IX_SEL = 4'h1;
	localparam logic [3:0] IX_CYL = 4'h2;
	localparam logic [3:0] IX_HD = 4'h3;
	localparam logic [3:0] IX_REC = 4'h4;
	localparam logic [3:0] IX_SIZE = 4'h5;
	localparam logic [3:0] IX_EOT = 4'h6;
	localparam logic [3:0] LEN_FULL = 4'h9;
	localparam logic [3:0] LEN_SHORT = 4'h2;
	localparam logic [2:0] RES_LEN_FULL = 3'h7;
	localparam logic [2:0] RES_LEN_BAD = 3'h1;
	localparam logic [7:0] ST0_INVALID = 8'h80;
	localparam logic [7:0] ST2_CTRL_MARK = 8'h40;
	localparam logic [7:0] FIRST_REC = 8'h01;
	typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RES} fdrc_phase_t;
	typedef enum logic [1:0] {EX_INDEX, EX_HUNT, EX_XFER, EX_SKIP} fdrc_exec_t;
endpackage : fdrc_pkg

//--- common/fdrc_sync_if.sv
interface fdrc_sync_if;
	logic raw;
	logic clean;
	modport user(output raw, input clean);
	modport syncer(input raw, output clean);
endinterface : fdrc_sync_if

//--- design/fdrc_sync.sv
module fdrc_sync (
	input wire logic clk,
	input wire logic srst,
	fdrc_sync_if.syncer s
);
	logic s1_r, s2_r, s3_r, clean_r;

	// idle level of an active-low pin is high
	always_ff @(posedge clk) begin
		if (srst) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
		end else begin
			s1_r <= s.raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a change counts only once two stages agree, filtering one-cycle glitches
	always_ff @(posedge clk) begin
		if (srst)
			clean_r <= 1'b1;
		else if (s2_r == s3_r)
			clean_r <= s3_r;
	end

	assign s.clean = clean_r;

	a_sync_agree: assert property (@(posedge clk) disable iff (srst)
		(s2_r == s3_r) |=> (clean_r == $past(s3_r)))
		else $error("pin filter did not follow agreed level");
endmodule : fdrc_sync

//--- design/fdrc_top.sv
module fdrc_top (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic CMD_WR,
	input wire logic [7:0] CMD_DATA,
	output logic CMD_READY,
	input wire logic RES_RD,
	output logic RES_VALID,
	output logic [7:0] RES_DATA,
	input wire logic INDEX_N,
	input wire logic ID_VALID,
	input wire logic ID_CRC_OK,
	input wire logic [31:0] ID_FIELD,
	input wire logic SECT_DELETED,
	input wire logic SECT_BYTE_VALID,
	input wire logic [7:0] SECT_BYTE,
	input wire logic SECT_END,
	output logic XFER_VALID,
	output logic [7:0] XFER_DATA,
	output logic READ_GATE,
	output logic HEAD_SEL,
	output logic [1:0] DRIVE_SEL,
	output logic DOUBLE_DENSITY
);
	fdrc_pkg::fdrc_phase_t phase_r;
	fdrc_pkg::fdrc_exec_t ex_r;
	logic [7:0] cmd_buf [0:8];
	logic [7:0] res_buf [0:6];
	logic [3:0] cnt_r, need_r;
	logic [2:0] res_len_r;
	logic [7:0] cur_rec_r, cur_hid_r, sec_cnt_r;
	logic side_r, mark_hit_r, idx_prev_r, xfer_valid_r;
	logic [7:0] xfer_data_r;
	logic [4:0] op;
	logic id_good, id_match, mark_wrong, last_sect, finish;
	logic [7:0] st0, st2, r_cyl, r_hd, r_rec, r_size;
	fdrc_sync_if idx_if();

	fdrc_sync u_idx (
		.clk(CLK),
		.srst(SRST),
		.s(idx_if.syncer)
	);
	assign idx_if.raw = INDEX_N;

	assign op = cmd_buf[fdrc_pkg::IX_OPC][4:0];
	assign CMD_READY = (phase_r == fdrc_pkg::PH_CMD);
	assign RES_VALID = (phase_r == fdrc_pkg::PH_RES);
	assign RES_DATA = res_buf[0];
	assign READ_GATE = (phase_r == fdrc_pkg::PH_EXEC);
	assign XFER_VALID = xfer_valid_r;
	assign XFER_DATA = xfer_data_r;
	assign HEAD_SEL = side_r;
	assign DRIVE_SEL = cmd_buf[fdrc_pkg::IX_SEL][1:0];
	assign DOUBLE_DENSITY = cmd_buf[fdrc_pkg::IX_OPC][fdrc_pkg::DD_BIT];

	function automatic logic [3:0] cmd_len(input logic [4:0] code);
		case (code)
			fdrc_pkg::OP_READ_DATA, fdrc_pkg::OP_READ_DELETED,
			fdrc_pkg::OP_READ_TRACK: cmd_len = fdrc_pkg::LEN_FULL;
			fdrc_pkg::OP_READ_ID: cmd_len = fdrc_pkg::LEN_SHORT;
			default: cmd_len = 4'h0;
		endcase
	endfunction : cmd_len

	// execution decisions
	always_comb begin
		id_good = ID_VALID && ID_CRC_OK;
		id_match = (ID_FIELD[31:24] == cmd_buf[fdrc_pkg::IX_CYL])
			&& (ID_FIELD[23:16] == cur_hid_r) && (ID_FIELD[15:8] == cur_rec_r)
			&& (ID_FIELD[7:0] == cmd_buf[fdrc_pkg::IX_SIZE]);
		// read data wants normal marks, read deleted wants deleted ones
		mark_wrong = SECT_DELETED != (op == fdrc_pkg::OP_READ_DELETED);
		last_sect = 1'b0;
		if (op == fdrc_pkg::OP_READ_TRACK)
			last_sect = (sec_cnt_r + 8'h01) == cmd_buf[fdrc_pkg::IX_EOT];
		else
			last_sect = (cur_rec_r == cmd_buf[fdrc_pkg::IX_EOT])
				&& !(cmd_buf[fdrc_pkg::IX_OPC][fdrc_pkg::MT_BIT] && !side_r);
		finish = 1'b0;
		if (phase_r == fdrc_pkg::PH_EXEC) begin
			if (ex_r == fdrc_pkg::EX_HUNT && id_good && op == fdrc_pkg::OP_READ_ID)
				finish = 1'b1;
			else if ((ex_r == fdrc_pkg::EX_XFER || ex_r == fdrc_pkg::EX_SKIP) && SECT_END)
				finish = last_sect || mark_hit_r;
		end
	end

	// result contents
	always_comb begin
		st0 = {5'h00, side_r, cmd_buf[fdrc_pkg::IX_SEL][1:0]};
		st2 = mark_hit_r ? fdrc_pkg::ST2_CTRL_MARK : 8'h00;
		r_cyl = cmd_buf[fdrc_pkg::IX_CYL];
		r_hd = cur_hid_r;
		r_rec = cur_rec_r;
		r_size = cmd_buf[fdrc_pkg::IX_SIZE];
		if (op == fdrc_pkg::OP_READ_ID && ex_r == fdrc_pkg::EX_HUNT) begin
			r_cyl = ID_FIELD[31:24];
			r_hd = ID_FIELD[23:16];
			r_rec = ID_FIELD[15:8];
			r_size = ID_FIELD[7:0];
		end
	end

	// phase sequencing and command capture
	always_ff @(posedge CLK) begin
		if (SRST) begin
			phase_r <= fdrc_pkg::PH_CMD;
			cnt_r <= 4'h0;
			need_r <= 4'h0;
			res_len_r <= 3'h0;
			for (int i = 0; i < 9; i++)
				cmd_buf[i] <= 8'h00;
			for (int i = 0; i < 7; i++)
				res_buf[i] <= 8'h00;
		end else begin
			case (phase_r)
				fdrc_pkg::PH_CMD: begin
					if (CMD_WR) begin
						cmd_buf[cnt_r] <= CMD_DATA;
						if (cnt_r == 4'h0 && cmd_len(CMD_DATA[4:0]) == 4'h0) begin
							// unknown opcode answers one invalid status byte
							res_buf[0] <= fdrc_pkg::ST0_INVALID;
							res_len_r <= fdrc_pkg::RES_LEN_BAD;
							phase_r <= fdrc_pkg::PH_RES;
						end else if (cnt_r == 4'h0) begin
							need_r <= cmd_len(CMD_DATA[4:0]);
							cnt_r <= 4'h1;
						end else if (cnt_r == need_r - 4'h1) begin
							cnt_r <= 4'h0;
							phase_r <= fdrc_pkg::PH_EXEC;
						end else begin
							cnt_r <= cnt_r + 4'h1;
						end
					end
				end
				fdrc_pkg::PH_EXEC: begin
					if (finish) begin
						res_buf[0] <= st0;
						res_buf[1] <= 8'h00;
						res_buf[2] <= st2;
						res_buf[3] <= r_cyl;
						res_buf[4] <= r_hd;
						res_buf[5] <= r_rec;
						res_buf[6] <= r_size;
						res_len_r <= fdrc_pkg::RES_LEN_FULL;
						phase_r <= fdrc_pkg::PH_RES;
					end
				end
				fdrc_pkg::PH_RES: begin
					if (RES_RD) begin
						for (int i = 0; i < 6; i++)
							res_buf[i] <= res_buf[i + 1];
						res_buf[6] <= 8'h00;
						res_len_r <= res_len_r - 3'h1;
						// back to commands only once every byte was taken
						if (res_len_r == 3'h1)
							phase_r <= fdrc_pkg::PH_CMD;
					end
				end
				default: phase_r <= fdrc_pkg::PH_CMD;
			endcase
		end
	end

	// execution walk over sectors
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ex_r <= fdrc_pkg::EX_HUNT;
			cur_rec_r <= 8'h00;
			cur_hid_r <= 8'h00;
			sec_cnt_r <= 8'h00;
			side_r <= 1'b0;
			mark_hit_r <= 1'b0;
			idx_prev_r <= 1'b1;
		end else begin
			idx_prev_r <= idx_if.clean;
			if (phase_r == fdrc_pkg::PH_CMD && CMD_WR && cnt_r == need_r - 4'h1
					&& cnt_r != 4'h0) begin
				side_r <= cmd_buf[fdrc_pkg::IX_SEL][fdrc_pkg::SIDE_BIT];
				cur_hid_r <= cmd_buf[fdrc_pkg::IX_HD];
				cur_rec_r <= cmd_buf[fdrc_pkg::IX_REC];
				sec_cnt_r <= 8'h00;
				mark_hit_r <= 1'b0;
				// the select byte may be the one arriving now
				if (need_r == fdrc_pkg::LEN_SHORT)
					side_r <= CMD_DATA[fdrc_pkg::SIDE_BIT];
				if (op == fdrc_pkg::OP_READ_TRACK)
					ex_r <= fdrc_pkg::EX_INDEX;
				else
					ex_r <= fdrc_pkg::EX_HUNT;
			end else if (phase_r == fdrc_pkg::PH_EXEC) begin
				case (ex_r)
					fdrc_pkg::EX_INDEX: begin
						if (idx_prev_r && !idx_if.clean)
							ex_r <= fdrc_pkg::EX_HUNT;
					end
					fdrc_pkg::EX_HUNT: begin
						// track read takes every sector with a good id in order, no compare
						if (id_good && op == fdrc_pkg::OP_READ_TRACK)
							ex_r <= fdrc_pkg::EX_XFER;
						else if (id_good && op != fdrc_pkg::OP_READ_ID && id_match) begin
							if (mark_wrong && cmd_buf[fdrc_pkg::IX_OPC][fdrc_pkg::SKIP_BIT])
								ex_r <= fdrc_pkg::EX_SKIP;
							else begin
								mark_hit_r <= mark_wrong;
								ex_r <= fdrc_pkg::EX_XFER;
							end
						end
					end
					fdrc_pkg::EX_XFER, fdrc_pkg::EX_SKIP: begin
						if (SECT_END && !finish) begin
							ex_r <= fdrc_pkg::EX_HUNT;
							sec_cnt_r <= sec_cnt_r + 8'h01;
							if (op != fdrc_pkg::OP_READ_TRACK
									&& cur_rec_r == cmd_buf[fdrc_pkg::IX_EOT]) begin
								side_r <= 1'b1;
								cur_hid_r <= cur_hid_r ^ 8'h01;
								cur_rec_r <= fdrc_pkg::FIRST_REC;
							end else begin
								cur_rec_r <= cur_rec_r + 8'h01;
							end
						end
					end
					default: ex_r <= fdrc_pkg::EX_HUNT;
				endcase
			end
		end
	end

	// data stream to host; a skipped sector produces nothing
	always_ff @(posedge CLK) begin
		if (SRST) begin
			xfer_valid_r <= 1'b0;
			xfer_data_r <= 8'h00;
		end else begin
			xfer_valid_r <= READ_GATE && ex_r == fdrc_pkg::EX_XFER && SECT_BYTE_VALID;
			if (READ_GATE && ex_r == fdrc_pkg::EX_XFER && SECT_BYTE_VALID)
				xfer_data_r <= SECT_BYTE;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	sequence s_last_cmd_byte;
		CMD_READY && CMD_WR && cnt_r != 4'h0 && cnt_r == need_r - 4'h1;
	endsequence
	sequence s_id_hit;
		READ_GATE && ex_r == fdrc_pkg::EX_HUNT && op == fdrc_pkg::OP_READ_ID && id_good;
	endsequence

	a_cmd_to_exec: assert property (s_last_cmd_byte |=> READ_GATE && !CMD_READY)
		else $error("command did not enter execution");
	a_opcode_short: assert property (CMD_READY && CMD_WR && cnt_r == 4'h0
		&& CMD_DATA[4:0] == fdrc_pkg::OP_READ_ID |=> need_r == fdrc_pkg::LEN_SHORT)
		else $error("read id length wrong");
	a_skip_silent: assert property (READ_GATE && ex_r == fdrc_pkg::EX_SKIP
		|=> !XFER_VALID)
		else $error("skipped sector transferred data");
	a_drive_select: assert property (CMD_READY && CMD_WR && cnt_r == fdrc_pkg::IX_SEL
		|=> DRIVE_SEL == $past(CMD_DATA[1:0]))
		else $error("drive select differs from select byte");
	a_xfer_byte: assert property (READ_GATE && ex_r == fdrc_pkg::EX_XFER
		&& SECT_BYTE_VALID |=> XFER_VALID && XFER_DATA == $past(SECT_BYTE))
		else $error("sector byte not passed on");
	a_result_len: assert property (READ_GATE && finish
		|=> RES_VALID && res_len_r == fdrc_pkg::RES_LEN_FULL)
		else $error("result length not seven");
	a_result_shift: assert property (RES_VALID && RES_RD && res_len_r > 3'h1
		|=> RES_VALID && RES_DATA == $past(res_buf[1]))
		else $error("result bytes out of order");
	a_track_index: assert property (READ_GATE && op == fdrc_pkg::OP_READ_TRACK
		&& ex_r == fdrc_pkg::EX_INDEX && idx_if.clean |=> ex_r == fdrc_pkg::EX_INDEX)
		else $error("track read started without index");
	a_id_capture: assert property (s_id_hit |=> RES_VALID
		&& res_buf[3] == $past(ID_FIELD[31:24]) && res_buf[6] == $past(ID_FIELD[7:0]))
		else $error("captured id not returned");
	// a new command may start at once, so only the cycle after the last pop is checked
	a_res_return: assert property (RES_VALID && RES_RD && res_len_r == 3'h1
		|=> CMD_READY && !RES_VALID && !READ_GATE)
		else $error("not back in command phase");
endmodule : fdrc_top

//--- tb/fdrc_drive_model.sv
module fdrc_drive_model (
	input wire logic clk,
	output logic index_n,
	output logic id_valid,
	output logic id_ok,
	output logic [31:0] id_field,
	output logic del,
	output logic bv,
	output logic [7:0] bt,
	output logic send
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		index_n = 1'b1;
		id_valid = 1'b0;
		id_ok = 1'b0;
		id_field = 32'h0;
		del = 1'b0;
		bv = 1'b0;
		bt = 8'h0;
		send = 1'b0;
	end
	// low long enough to pass the pin filter
	task automatic index_pulse();
		index_n = 1'b0;
		repeat (6) @(posedge clk);
		#2 index_n = 1'b1;
		repeat (8) @(posedge clk);
		#2;
	endtask : index_pulse
	task automatic sector(input logic [31:0] id, input logic ok, input logic d,
		input int cnt, input logic [7:0] b0);
		id_field = id;
		id_ok = ok;
		del = d;
		id_valid = 1'b1;
		@(posedge clk);
		// released lines must not keep looking valid
		#2 id_valid = 1'b0;
		id_field = ~id;
		id_ok = ~ok;
		del = ~d;
		for (int i = 0; i < cnt; i++) begin
			@(posedge clk);
			#2 bt = b0 + 8'(i);
			bv = 1'b1;
			@(posedge clk);
			#2 bv = 1'b0;
			bt = ~bt;
		end
		@(posedge clk);
		#2 send = 1'b1;
		@(posedge clk);
		#2 send = 1'b0;
		repeat (3) @(posedge clk);
		#2;
	endtask : sector
endmodule : fdrc_drive_model

//--- tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst, cmd_wr, res_rd, cmd_ready, res_valid, xv, rg, hs, dd;
	logic [7:0] cmd_data, res_data, xd, bt, c;
	logic [1:0] ds;
	logic index_n, id_valid, id_ok, del, bv, send;
	logic [31:0] id_field;
	int miscompares = 0;
	int comparisons = 0;
	logic [7:0] xq[$];
	int rq[$];
	fdrc_top u_fdrc_top (.CLK(clk), .SRST(srst), .CMD_WR(cmd_wr), .CMD_DATA(cmd_data),
		.CMD_READY(cmd_ready), .RES_RD(res_rd), .RES_VALID(res_valid), .RES_DATA(res_data),
		.INDEX_N(index_n), .ID_VALID(id_valid), .ID_CRC_OK(id_ok), .ID_FIELD(id_field),
		.SECT_DELETED(del), .SECT_BYTE_VALID(bv), .SECT_BYTE(bt), .SECT_END(send),
		.XFER_VALID(xv), .XFER_DATA(xd), .READ_GATE(rg), .HEAD_SEL(hs),
		.DRIVE_SEL(ds), .DOUBLE_DENSITY(dd));
	fdrc_drive_model u_fdrc_drive_model (.clk(clk), .index_n(index_n), .id_valid(id_valid),
		.id_ok(id_ok), .id_field(id_field), .del(del), .bv(bv), .bt(bt), .send(send));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp
	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// unexpected transfers compare against x and so always fail
	always @(posedge clk) begin
		if (xv === 1'b1)
			cmp(xd, (xq.size() > 0) ? xq.pop_front() : 8'hxx, "xfer");
	end
	task automatic send_cmd(input logic [7:0] b[$]);
		foreach (b[i]) begin
			cmd_wr = 1'b1;
			cmd_data = b[i];
			@(posedge clk);
			#2;
		end
		cmd_wr = 1'b0;
		cmd_data = ~cmd_data;
	endtask : send_cmd
	task automatic sec(input logic [31:0] id, input logic d, input logic ok, input bit take);
		logic [7:0] b0;
		int n;
		b0 = 8'($urandom);
		n = 1 + int'($urandom % 4);
		for (int i = 0; i < n && take; i++)
			xq.push_back(b0 + 8'(i));
		u_fdrc_drive_model.sector(id, ok, d, n, b0);
	endtask : sec
	task automatic results();
		int n;
		int e;
		n = 0;
		while (res_valid !== 1'b1) begin
			@(posedge clk);
			#2 n++;
			if (n > 2000) begin
				miscompares++;
				summarize();
			end
		end
		while (rq.size() > 0) begin
			e = rq.pop_front();
			cmp({7'h00, res_valid}, 8'h01, "res valid");
			if (e >= 0)
				cmp(res_data, 8'(e), "result");
			res_rd = 1'b1;
			@(posedge clk);
			#2;
		end
		res_rd = 1'b0;
		cmp({7'h00, cmd_ready}, 8'h01, "ready after results");
		cmp({7'h00, res_valid}, 8'h00, "res done");
		cmp(8'(xq.size()), 8'h00, "xfer left");
	endtask : results
	initial begin
		void'($urandom(84));
		srst = 1'b1;
		cmd_wr = 1'b0;
		cmd_data = 8'h0;
		res_rd = 1'b0;
		repeat (6) @(posedge clk);
		#2 cmp({cmd_ready, res_valid, xv, rg, hs, ds, dd}, 8'h80, "reset flags");
		cmp(res_data | xd, 8'h0, "reset data");
		srst = 1'b0;
		repeat (5) @(posedge clk);
		#2 c = 8'($urandom);
		// read identifier, side 1 drive 2, double density
		send_cmd('{8'h4a, 8'h06});
		cmp({2'h0, cmd_ready, rg, hs, ds, dd}, 8'h1d, "id start");
		// let an edge pass so the write strobe is not raised in the step it fell
		@(posedge clk);
		#2 send_cmd('{8'h0a});
		sec({c, 8'h01, 8'h07, 8'h02}, 1'b0, 1'b0, 1'b0);
		sec({c, 8'h00, 8'h03, 8'h02}, 1'b0, 1'b1, 1'b0);
		rq = '{8'h06, 0, 0, c, 8'h00, 8'h03, 8'h02};
		results();
		// read data, multitrack, side 0 drive 1, single density
		send_cmd('{8'h86, 8'h01, c, 8'h00, 8'h01, 8'h02, 8'h01, 8'h1b, 8'hff});
		cmp({2'h0, cmd_ready, rg, hs, ds, dd}, 8'h12, "data start");
		sec({c, 8'h00, 8'h09, 8'h02}, 1'b0, 1'b1, 1'b0);
		sec({c, 8'h00, 8'h01, 8'h02}, 1'b0, 1'b1, 1'b1);
		sec({c, 8'h01, 8'h01, 8'h02}, 1'b0, 1'b1, 1'b1);
		rq = '{8'h05, 0, 0, c, 8'h01, 8'h01, 8'h02};
		results();
		// read deleted: a normal mark without skip ends the command
		send_cmd('{8'h4c, 8'h02, c, 8'h00, 8'h02, 8'h01, 8'h09, 8'h1b, 8'hff});
		sec({c, 8'h00, 8'h02, 8'h01}, 1'b1, 1'b1, 1'b1);
		sec({c, 8'h00, 8'h03, 8'h01}, 1'b0, 1'b1, 1'b1);
		rq = '{8'h02, 0, 8'h40, c, 8'h00, 8'h03, 8'h01};
		results();
		// read data with skip: a deleted sector is dropped, the next one ends it
		send_cmd('{8'h26, 8'h00, c, 8'h00, 8'h01, 8'h02, 8'h02, 8'h1b, 8'hff});
		sec({c, 8'h00, 8'h01, 8'h02}, 1'b1, 1'b1, 1'b0);
		sec({c, 8'h00, 8'h02, 8'h02}, 1'b0, 1'b1, 1'b1);
		rq = '{8'h00, 0, 0, c, 8'h00, 8'h02, 8'h02};
		results();
		// read track from index through two sectors
		send_cmd('{8'h42, 8'h00, c, 8'h00, 8'h01, 8'h02, 8'h02, 8'h1b, 8'hff});
		u_fdrc_drive_model.index_pulse();
		sec({~c, 8'h00, 8'h07, 8'h02}, 1'b0, 1'b1, 1'b1);
		sec({~c, 8'h00, 8'h04, 8'h02}, 1'b0, 1'b1, 1'b1);
		rq = '{8'h00, 0, 0, c, 8'h00, 8'h02, 8'h02};
		results();
		// unknown opcode gives one status byte
		send_cmd('{8'h1f});
		cmp({6'h00, rg, res_valid}, 8'h01, "bad op");
		rq = '{8'h80};
		results();
		summarize();
	end
endmodule : tb_top
